// ===== src/nvm_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_access_ctrl #(
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES,
  parameter int TIMER_W = nvm_pkg::TIMER_W
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // device resets that may cut a write
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_timer_rst,
  // register file access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // status
  output logic program_done_flag,
  output logic nvm_write_busy
);

  // ============================================================
  // state
  // ============================================================
  logic [nvm_pkg::DATA_W-1:0] data_ff;     // nvm_data_reg
  logic [nvm_pkg::ADDR_W-1:0] addr_ff;     // nvm_addr_reg
  logic rd_bit_ff;                         // read start
  logic wr_bit_ff;                         // write start / busy
  logic permit_ff;                         // program_permit
  logic abort_ff;                          // program_abort_flag
  logic done_ff;                           // program_done_flag
  logic [nvm_pkg::ADDR_W-1:0] lat_addr_ff; // write target copy
  logic [nvm_pkg::DATA_W-1:0] lat_data_ff; // write byte copy
  logic [7:0] rdata_ff;                    // read data to cpu
  nvm_pkg::nvm_seq_type seq_ff;            // unlock tracker
  logic [nvm_pkg::GAP_W-1:0] gap_ff;       // cycles since last step
  // the store itself, no reset: contents survive resets
  logic [nvm_pkg::DATA_W-1:0] mem_ff [0:nvm_pkg::MEM_DEPTH-1];

  // ============================================================
  // decode
  // ============================================================
  logic warm;        // device reset cutting this block
  logic wr_data;     // write to data register
  logic wr_addr;     // write to address register
  logic wr_ctrl;     // write to control register
  logic wr_key;      // write to key port
  logic wr_pflag;    // write to peripheral flags
  logic lone_rd;     // read with no write beside it
  logic gap_ok;      // exact spacing reached
  logic start_ok;    // write start accepted
  logic rd_start;    // read start requested
  logic timer_done;  // timed write ends this cycle
  logic timer_busy;  // timer running
  logic [nvm_pkg::DATA_W-1:0] rd_peek; // byte at current address

  assign warm = !ext_reset_pin_n || watchdog_timer_rst;
  assign wr_data = sfr_wr && (sfr_addr == nvm_pkg::ADDR_DATA);
  assign wr_addr = sfr_wr && (sfr_addr == nvm_pkg::ADDR_ADDR);
  assign wr_ctrl = sfr_wr && (sfr_addr == nvm_pkg::ADDR_CTRL);
  assign wr_key = sfr_wr && (sfr_addr == nvm_pkg::ADDR_KEY);
  assign wr_pflag = sfr_wr && (sfr_addr == nvm_pkg::ADDR_PFLAG);
  assign lone_rd = sfr_rd && !sfr_wr;
  assign gap_ok = (gap_ff == nvm_pkg::GAP_MATCH);
  assign rd_peek = mem_ff[addr_ff];
  assign rd_start = wr_ctrl && sfr_wdata[nvm_pkg::CTRL_RD_BIT];

  // write start only from an armed sequence at the exact cycle,
  // with permit already high and no write running
  assign start_ok = wr_ctrl && sfr_wdata[nvm_pkg::CTRL_WR_BIT] &&
                    (seq_ff == nvm_pkg::NVM_SEQ_ARMED) && gap_ok &&
                    permit_ff && !wr_bit_ff && !warm;

  // ============================================================
  // write duration timer
  // ============================================================
  nvm_write_timer #(
    .CNT_W(TIMER_W),
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .start(start_ok),
    .abort(warm),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ============================================================
  // unlock sequence tracker
  // ============================================================
  // any access other than the next step drops the tracker, so an
  // interrupt landing mid-sequence simply costs the write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_ff <= nvm_pkg::NVM_SEQ_IDLE;
      gap_ff <= nvm_pkg::GAP_ZERO;
    end else if (ce) begin
      if (gap_ff != nvm_pkg::GAP_MAX) begin
        gap_ff <= gap_ff + 3'h1;
      end
      if (warm) begin
        seq_ff <= nvm_pkg::NVM_SEQ_IDLE;
      end else if (wr_key && sfr_wdata == nvm_pkg::KEY_FIRST) begin
        // first key (re)starts the sequence
        seq_ff <= nvm_pkg::NVM_SEQ_KEY1;
        gap_ff <= nvm_pkg::GAP_ZERO;
      end else if (wr_key && sfr_wdata == nvm_pkg::KEY_SECOND &&
                   seq_ff == nvm_pkg::NVM_SEQ_KEY1 && gap_ok) begin
        seq_ff <= nvm_pkg::NVM_SEQ_ARMED;
        gap_ff <= nvm_pkg::GAP_ZERO;
      end else if (sfr_wr || lone_rd) begin
        // wrong step or the single use of the armed state
        seq_ff <= nvm_pkg::NVM_SEQ_IDLE;
      end else if (gap_ok) begin
        // step cycle passed without the step: count is off
        seq_ff <= nvm_pkg::NVM_SEQ_IDLE;
      end
    end
  end

  // ============================================================
  // address register
  // ============================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_ff <= nvm_pkg::RST_BYTE;
    end else if (ce) begin
      if (warm) begin
        addr_ff <= nvm_pkg::RST_BYTE;
      end else if (wr_addr) begin
        addr_ff <= sfr_wdata;
      end
    end
  end

  // ============================================================
  // data register
  // ============================================================
  // changes only by a read, a software write or a warm reset clearing it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_ff <= nvm_pkg::RST_BYTE;
    end else if (ce) begin
      if (warm) begin
        data_ff <= nvm_pkg::RST_BYTE;
      end else if (rd_start) begin
        data_ff <= rd_peek;
      end else if (wr_data) begin
        data_ff <= sfr_wdata;
      end
    end
  end

  // ============================================================
  // read start bit
  // ============================================================
  // the read itself finishes at the setting edge; the bit shows
  // for exactly one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_bit_ff <= nvm_pkg::RST_BIT;
    end else if (ce) begin
      rd_bit_ff <= rd_start && !warm;
    end
  end

  // ============================================================
  // write start bit and latched target
  // ============================================================
  // a zero written to the bit is ignored, so software can never
  // cut a write short
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_bit_ff <= nvm_pkg::RST_BIT;
      lat_addr_ff <= nvm_pkg::RST_BYTE;
      lat_data_ff <= nvm_pkg::RST_BYTE;
    end else if (ce) begin
      if (warm) begin
        wr_bit_ff <= 1'b0;
      end else if (start_ok) begin
        wr_bit_ff <= 1'b1;
        lat_addr_ff <= addr_ff;
        lat_data_ff <= data_ff;
      end else if (timer_done) begin
        wr_bit_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // permit bit
  // ============================================================
  // only software and a warm reset move it; the running write ignores it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      permit_ff <= nvm_pkg::RST_BIT;
    end else if (ce) begin
      if (warm) begin
        permit_ff <= 1'b0;
      end else if (wr_ctrl) begin
        permit_ff <= sfr_wdata[nvm_pkg::CTRL_PERMIT_BIT];
      end
    end
  end

  // ============================================================
  // abort flag
  // ============================================================
  // power-up value is undefined for software; cleared here anyway
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abort_ff <= nvm_pkg::RST_BIT;
    end else if (ce) begin
      if (warm && wr_bit_ff) begin
        abort_ff <= 1'b1;
      end else if (wr_ctrl && !warm) begin
        abort_ff <= sfr_wdata[nvm_pkg::CTRL_ABORT_BIT];
      end
    end
  end

  // ============================================================
  // done flag
  // ============================================================
  // the hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_ff <= nvm_pkg::RST_BIT;
    end else if (ce) begin
      if (warm) begin
        done_ff <= 1'b0;
      end else if (timer_done) begin
        done_ff <= 1'b1;
      end else if (wr_pflag) begin
        done_ff <= sfr_wdata[nvm_pkg::PFLAG_DONE_BIT];
      end
    end
  end

  // ============================================================
  // store
  // ============================================================
  // a byte write overwrites the whole location in one step
  always_ff @(posedge ref_clk) begin
    if (ce && timer_done && !warm) begin
      mem_ff[lat_addr_ff] <= lat_data_ff;
    end
  end

  // ============================================================
  // read data
  // ============================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= nvm_pkg::RST_BYTE;
    end else if (ce && sfr_rd) begin
      case (sfr_addr)
        nvm_pkg::ADDR_DATA: rdata_ff <= data_ff;
        nvm_pkg::ADDR_ADDR: rdata_ff <= addr_ff;
        nvm_pkg::ADDR_CTRL: begin
          rdata_ff <= {4'h0, abort_ff, permit_ff, wr_bit_ff, rd_bit_ff};
        end
        nvm_pkg::ADDR_PFLAG: rdata_ff <= {done_ff, 7'h00};
        nvm_pkg::ADDR_KEY: rdata_ff <= nvm_pkg::RST_BYTE;
        default: rdata_ff <= nvm_pkg::RST_BYTE;
      endcase
    end
  end

  assign sfr_rdata = rdata_ff;
  assign program_done_flag = done_ff;
  assign nvm_write_busy = wr_bit_ff;

  // ============================================================
  // checks
  // ============================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_rd_one_cycle: assert property (ce && rd_bit_ff && !rd_start |=> !rd_bit_ff)
    else $error("read start bit stayed set");

  a_rd_data_next: assert property (
    ce && rd_start && !warm |=> data_ff == $past(rd_peek))
    else $error("read byte missing from data register");

  a_wr_no_clear: assert property (
    ce && wr_bit_ff && wr_ctrl && !sfr_wdata[1] && !timer_done && !warm
    |=> wr_bit_ff)
    else $error("software cleared write start");

  a_wr_needs_permit: assert property ($rose(wr_bit_ff) |-> $past(permit_ff))
    else $error("write started without permit");

  a_wr_needs_seq: assert property (
    $rose(wr_bit_ff) |-> $past(seq_ff) == nvm_pkg::NVM_SEQ_ARMED &&
    $past(gap_ff) == nvm_pkg::GAP_MATCH)
    else $error("write started without exact unlock");

  a_done_sets: assert property (
    ce && timer_done && !warm |=> done_ff && !wr_bit_ff)
    else $error("write end did not set done");

  a_permit_keep: assert property (
    ce && permit_ff && !wr_ctrl && !warm |=> permit_ff)
    else $error("permit changed without software");

  a_abort_flag: assert property (ce && warm && wr_bit_ff |=> abort_ff)
    else $error("cut write did not set abort flag");

  a_ctrl_upper: assert property (
    ce && sfr_rd && sfr_addr == nvm_pkg::ADDR_CTRL |=> sfr_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");

  a_key_zero: assert property (
    ce && sfr_rd && sfr_addr == nvm_pkg::ADDR_KEY |=> sfr_rdata == 8'h00)
    else $error("key port read not zero");

  a_latch_hold: assert property (
    wr_bit_ff && $past(wr_bit_ff) |-> $stable(lat_addr_ff) && $stable(lat_data_ff))
    else $error("latched target changed mid write");

  a_timer_tracks: assert property (wr_bit_ff == timer_busy)
    else $error("write start and timer disagree");

endmodule
`default_nettype wire

// ===== src/nvm_pkg.sv
// ============================================================
// shared constants for the data store access block
// ============================================================
package nvm_pkg;

  // ============================================================
  // widths and array size
  // ============================================================
  localparam int DATA_W = 8;     // byte wide store
  localparam int ADDR_W = 8;     // full 8-bit location index
  localparam int MEM_DEPTH = 256; // locations in the store

  // ============================================================
  // register file offsets
  // ============================================================
  localparam logic [7:0] ADDR_PFLAG = 8'h0C; // peripheral_flag_reg
  localparam logic [7:0] ADDR_DATA = 8'h9A;  // nvm_data_reg
  localparam logic [7:0] ADDR_ADDR = 8'h9B;  // nvm_addr_reg
  localparam logic [7:0] ADDR_CTRL = 8'h9C;  // nvm_control_reg
  localparam logic [7:0] ADDR_KEY = 8'h9D;   // unlock_key_port

  // ============================================================
  // field positions
  // ============================================================
  localparam int CTRL_RD_BIT = 0;     // read start
  localparam int CTRL_WR_BIT = 1;     // write start
  localparam int CTRL_PERMIT_BIT = 2; // program_permit
  localparam int CTRL_ABORT_BIT = 3;  // program_abort_flag
  localparam int PFLAG_DONE_BIT = 7;  // program_done_flag

  // ============================================================
  // reset values and keys
  // ============================================================
  localparam logic [7:0] RST_BYTE = 8'h00;   // data, address, read data
  localparam logic RST_BIT = 1'b0;           // every control bit
  localparam logic [7:0] KEY_FIRST = 8'h55;  // first unlock key
  localparam logic [7:0] KEY_SECOND = 8'hAA; // second unlock key

  // ============================================================
  // timing
  // ============================================================
  // instruction cycles from one unlock step to the next
  localparam int UNLOCK_GAP_CYCLES = 2;
  localparam int GAP_W = 3;
  localparam logic [2:0] GAP_MATCH = 3'(UNLOCK_GAP_CYCLES - 1);
  localparam logic [2:0] GAP_MAX = 3'h7;
  localparam logic [2:0] GAP_ZERO = 3'h0;
  localparam int CLK_PERIOD_NS = 10;
  // self-timed write duration, plain default
  localparam int WRITE_TIME_NS = 5000000;
  // longest time, rounded down, at least one cycle
  localparam int WRITE_CYCLES = (WRITE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  // ============================================================
  // unlock sequence tracker
  // ============================================================
  typedef enum logic [1:0] {
    NVM_SEQ_IDLE = 2'b00,
    NVM_SEQ_KEY1 = 2'b01,
    NVM_SEQ_ARMED = 2'b11
  } nvm_seq_type;

endpackage

// ===== src/nvm_write_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-timed write duration counter
// ============================================================
module nvm_write_timer #(
  parameter int CNT_W = 20,
  parameter int CYCLES = 500000
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic abort,
  // status
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_ff;  // cycles left
  logic busy_ff;             // timing in progress

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  // count down while busy; abort wins over everything
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (abort) begin
        busy_ff <= 1'b0;
      end else if (start) begin
        cnt_ff <= LOAD;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == ONE) begin
          busy_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - ONE;
        end
      end
    end
  end

  assign busy = busy_ff;
  // last cycle of the timed window
  assign done = busy_ff && (cnt_ff == ONE);

endmodule
`default_nettype wire

// ===== tb/test_nvm_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// comparison helper, counts every compare
// ============================================================
`define NVM_CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", what, exp, got); end end
module test_nvm_access_ctrl;
  // ============================================================
  // bench signals
  // ============================================================
  localparam int WCYC = 20; // short write time keeps the run brief
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // dropped for three cycles inside each disturbed write
  logic ext_reset_pin_n = 1'b1;
  logic watchdog_timer_rst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic program_done_flag;
  logic nvm_write_busy;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'hff2f0826;
  logic [7:0] exp_mem [256]; // expected store contents
  bit known [256];           // locations written so far
  logic [7:0] v;
  // ============================================================
  // device under test
  // ============================================================
  nvm_access_ctrl #(.WRITE_CYCLES(WCYC), .TIMER_W(nvm_pkg::TIMER_W)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .ext_reset_pin_n(ext_reset_pin_n),
    .watchdog_timer_rst(watchdog_timer_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .program_done_flag(program_done_flag), .nvm_write_busy(nvm_write_busy));
  // ============================================================
  // clock and hang guard
  // ============================================================
  always #5 ref_clk = ~ref_clk;
  // ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  // ============================================================
  // expectation helpers
  // ============================================================
  // control byte: upper nibble and start bits read zero when idle
  function automatic logic [7:0] exp_ctrl(input logic permit, input logic abort);
    return {4'h0, abort, permit, 2'b00};
  endfunction
  // ============================================================
  // register bus tasks
  // ============================================================
  // one write, taken at the second edge; a call right after spaces by two
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  // one read; data is registered at the taking edge, sampled just after
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    q = sfr_rdata;
  endtask
  // store read through address, read start, then data register
  task automatic ee_read(input logic [7:0] a, output logic [7:0] q);
    wr(nvm_pkg::ADDR_ADDR, a);
    // permit stays low: a read never needs it
    wr(nvm_pkg::ADDR_CTRL, 8'h01);
    rd(nvm_pkg::ADDR_DATA, q);
  endtask
  // guarded write; bad: 0 exact, 1 late key, 2 late start, 3 keys swapped,
  // 4 permit low; mid: disturb data and permit while the write runs
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d, input int bad,
                          input bit mid);
    int n;
    n = 0;
    wr(nvm_pkg::ADDR_ADDR, a);
    wr(nvm_pkg::ADDR_DATA, d);
    wr(nvm_pkg::ADDR_CTRL, (bad == 4) ? 8'h00 : 8'h04);
    wr(nvm_pkg::ADDR_KEY, (bad == 3) ? nvm_pkg::KEY_SECOND : nvm_pkg::KEY_FIRST);
    if (bad == 1) @(posedge ref_clk);
    wr(nvm_pkg::ADDR_KEY, (bad == 3) ? nvm_pkg::KEY_FIRST : nvm_pkg::KEY_SECOND);
    if (bad == 2) @(posedge ref_clk);
    wr(nvm_pkg::ADDR_CTRL, (bad == 4) ? 8'h02 : 8'h06);
    #1;
    `NVM_CHK("write busy", (bad == 0), nvm_write_busy)
    if (bad == 0) begin
      // n counts edges after the starting edge
      n = 0;
      if (mid) begin
        wr(nvm_pkg::ADDR_DATA, ~d);
        wr(nvm_pkg::ADDR_CTRL, 8'h00);
        #1;
        `NVM_CHK("busy after zero write", 1'b1, nvm_write_busy)
        // frozen edges must not advance the write timer
        @(posedge ref_clk);
        ce <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ce <= 1'b1;
        #1;
        `NVM_CHK("busy while frozen", 1'b1, nvm_write_busy)
        n = 8;
      end
      while (program_done_flag !== 1'b1 && n < 200) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      `NVM_CHK("write cycles", (mid ? WCYC + 3 : WCYC), n)
      `NVM_CHK("busy at end", 1'b0, nvm_write_busy)
      rd(nvm_pkg::ADDR_CTRL, v);
      `NVM_CHK("permit kept", exp_ctrl(!mid, 1'b0), v)
      rd(nvm_pkg::ADDR_PFLAG, v);
      `NVM_CHK("done flag", 8'h80, v)
      wr(nvm_pkg::ADDR_PFLAG, 8'h00);
      #1;
      exp_mem[a] = d;
      known[a] = 1'b1;
    end
    `NVM_CHK("done cleared", 1'b0, program_done_flag)
  endtask
  // ============================================================
  // verdict
  // ============================================================
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values and read-as-zero places
    rd(nvm_pkg::ADDR_CTRL, v);
    `NVM_CHK("ctrl reset", 8'h00, v)
    wr(nvm_pkg::ADDR_CTRL, 8'hf0);
    rd(nvm_pkg::ADDR_CTRL, v);
    `NVM_CHK("ctrl upper nibble", 8'h00, v)
    wr(nvm_pkg::ADDR_KEY, nvm_pkg::KEY_FIRST);
    rd(nvm_pkg::ADDR_KEY, v);
    `NVM_CHK("key port", 8'h00, v)
    wr(8'h50, 8'h5a);
    rd(8'h50, v);
    `NVM_CHK("unmapped", 8'h00, v)
    $display("test reset and read-zero done");
    // every broken sequence is refused, the store keeps its value
    ee_write(8'h00, 8'h3c, 0, 1'b0);
    for (int b = 1; b <= 4; b++) begin
      ee_write(8'h00, 8'hc3, b, 1'b0);
    end
    ee_read(8'h00, v);
    `NVM_CHK("store after refusals", 8'h3c, v)
    rd(nvm_pkg::ADDR_CTRL, v);
    `NVM_CHK("read start cleared", 8'h00, v)
    rd(nvm_pkg::ADDR_DATA, v);
    `NVM_CHK("data held", 8'h3c, v)
    $display("test refused sequences done");
    // random writes with the top corner address 8'hff, some disturbed mid-write
    ee_write(8'hff, 8'h00, 0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      ee_write(a, d, 0, i[0]);
    end
    for (int k = 0; k < 256; k++) begin
      if (known[k]) begin
        ee_read(k[7:0], v);
        `NVM_CHK("store readback", exp_mem[k], v)
      end
    end
    $display("test random writes done");
    // warm reset of each kind cuts a running write
    for (int s = 0; s < 2; s++) begin
      wr(nvm_pkg::ADDR_ADDR, 8'h00);
      wr(nvm_pkg::ADDR_DATA, 8'h99);
      wr(nvm_pkg::ADDR_CTRL, 8'h04);
      wr(nvm_pkg::ADDR_KEY, nvm_pkg::KEY_FIRST);
      wr(nvm_pkg::ADDR_KEY, nvm_pkg::KEY_SECOND);
      wr(nvm_pkg::ADDR_CTRL, 8'h06);
      repeat (3) @(posedge ref_clk);
      if (s == 0) ext_reset_pin_n <= 1'b0;
      else watchdog_timer_rst <= 1'b1;
      @(posedge ref_clk);
      ext_reset_pin_n <= 1'b1;
      watchdog_timer_rst <= 1'b0;
      #1;
      `NVM_CHK("busy after cut", 1'b0, nvm_write_busy)
      rd(nvm_pkg::ADDR_CTRL, v);
      `NVM_CHK("abort flag", exp_ctrl(1'b0, 1'b1), v)
      rd(nvm_pkg::ADDR_DATA, v);
      `NVM_CHK("data cleared", 8'h00, v)
      rd(nvm_pkg::ADDR_ADDR, v);
      `NVM_CHK("addr cleared", 8'h00, v)
      wr(nvm_pkg::ADDR_CTRL, 8'h00);
      rd(nvm_pkg::ADDR_CTRL, v);
      `NVM_CHK("abort cleared", 8'h00, v)
    end
    ee_read(8'h00, v);
    // a random write may have landed on location zero as well
    `NVM_CHK("store kept after cut", exp_mem[0], v)
    $display("test warm reset done");
    finish_test();
  end
endmodule
`default_nettype wire
